/* mpd_pkg.sv */
// mpd_pkg: constants, types and carriers for the mains phase detector
// assumes a 200 MHz core clock and a one-cycle zero-crossing pulse input
package mpd_pkg;

  localparam int unsigned MPD_CLK_HZ = 200000000;
  localparam int unsigned MPD_MAINS_50_HZ = 50;
  localparam int unsigned MPD_MAINS_60_HZ = 60;
  localparam int unsigned MPD_TICKS_PER_PERIOD = 256;
  // tick rates in Hz: 12.8 kHz and 15.36 kHz
  localparam int unsigned MPD_TICK_RATE_50_HZ = MPD_MAINS_50_HZ * MPD_TICKS_PER_PERIOD;
  localparam int unsigned MPD_TICK_RATE_60_HZ = MPD_MAINS_60_HZ * MPD_TICKS_PER_PERIOD;
  // clock cycles per phase tick, rounded down
  localparam int unsigned MPD_DIV_50 = MPD_CLK_HZ / MPD_TICK_RATE_50_HZ;
  localparam int unsigned MPD_DIV_60 = MPD_CLK_HZ / MPD_TICK_RATE_60_HZ;
  localparam int unsigned MPD_DIV_W = 16;
  localparam logic [MPD_DIV_W-1:0] MPD_DIV_50_C = MPD_DIV_W'(MPD_DIV_50);
  localparam logic [MPD_DIV_W-1:0] MPD_DIV_60_C = MPD_DIV_W'(MPD_DIV_60);

  localparam int unsigned MPD_COUNT_W = 8;
  localparam int unsigned MPD_CODE_W = 3;
  localparam int unsigned MPD_NBR_W = 5;
  localparam int unsigned MPD_NBR_DEPTH = 32;
  // sixty degrees as 42.66 counts, held in hundredths
  localparam int unsigned MPD_SIXTY_DEG_X100 = 4266;
  localparam logic [MPD_COUNT_W:0] MPD_WRAP = 9'h100;
  localparam logic [MPD_COUNT_W-1:0] MPD_COUNT_RST = 8'h00;
  localparam logic [MPD_DIV_W-1:0] MPD_DIV_RST = 16'h0000;
  localparam logic [MPD_CODE_W-1:0] MPD_CODE_RST = 3'h0;

  typedef logic [MPD_COUNT_W-1:0] mpd_count_t;
  typedef logic [MPD_CODE_W-1:0] mpd_code_t;

  // stored per neighbour: offset code and inversion flag
  typedef struct packed {
    mpd_code_t phase_offset_code;
    logic inverted;
  } mpd_result_s;

  // receive job: neighbour index, carried transmit stamp, rx delay in ticks
  typedef struct packed {
    logic [MPD_NBR_W-1:0] nbr_idx;
    mpd_count_t tx_phase_stamp;
    mpd_count_t rx_delay_ticks;
  } mpd_rx_job_s;

  typedef enum logic [1:0] {
    MPD_IDLE,
    MPD_DELTA,
    MPD_CODE,
    MPD_STORE
  } mpd_state_e;

endpackage : mpd_pkg

/* mpd_nbr_mem.sv */
// mpd_nbr_mem: neighbour table phase results, one write and one read port
// assumes single clock; read data registered, valid one cycle after request
`timescale 1ns/100ps
`default_nettype none
module mpd_nbr_mem
  import mpd_pkg::*;
#(
  parameter int unsigned DEPTH = MPD_NBR_DEPTH,
  parameter int unsigned AW = MPD_NBR_W
) (
  input wire logic core_clk_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire mpd_result_s wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output mpd_result_s rd_data_o
);

  mpd_result_s mem [DEPTH];

  // write port and registered read
  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule : mpd_nbr_mem
`default_nettype wire

/* mpd_phase_detector.sv */
// mpd_phase_detector: phase counter, tx stamping, rx stamp and offset code
// assumes zc pulse is one cycle wide, sourced from a rising-edge zero-crossing detector
`timescale 1ns/100ps
`default_nettype none
module mpd_phase_detector
  import mpd_pkg::*;
#(
  parameter int unsigned NBR_DEPTH = MPD_NBR_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic zc_pulse_i,
  input wire logic mains_60hz_i,
  input wire logic tx_req_i,
  input wire mpd_count_t tx_delay_ticks_i,
  output mpd_count_t tx_phase_stamp_o,
  output logic tx_stamp_valid_o,
  input wire logic rx_detect_i,
  input wire mpd_rx_job_s rx_job_i,
  output mpd_code_t phase_offset_code_o,
  output logic inverted_o,
  output logic result_valid_o,
  input wire logic get_req_i,
  input wire logic [MPD_NBR_W-1:0] get_idx_i,
  output mpd_result_s get_data_o,
  output logic get_valid_o,
  output mpd_count_t phase_count_o
);

  ////////////////////////////////////////////////////////////////////////////
  // phase counter

  logic [MPD_DIV_W-1:0] div_r, div_nxt;
  mpd_count_t phase_count_r, phase_count_nxt;

  // selects cycles per tick for the mains frequency
  function automatic logic [MPD_DIV_W-1:0] tick_div(input logic is60);
    tick_div = is60 ? MPD_DIV_60_C : MPD_DIV_50_C;
  endfunction : tick_div

  // rising-edge zc pulse restarts count; ticks wrap 255 to 0
  always_comb begin
    div_nxt = div_r;
    phase_count_nxt = phase_count_r;
    if (zc_pulse_i) begin
      div_nxt = MPD_DIV_RST;
      phase_count_nxt = MPD_COUNT_RST;
    end else if (div_r == tick_div(mains_60hz_i) - 16'h0001) begin
      div_nxt = MPD_DIV_RST;
      phase_count_nxt = phase_count_r + 8'h01;
    end else begin
      div_nxt = div_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      div_r <= MPD_DIV_RST;
      phase_count_r <= MPD_COUNT_RST;
    end else if (ce_i) begin
      div_r <= div_nxt;
      phase_count_r <= phase_count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit stamp

  mpd_count_t tx_stamp_r, tx_stamp_nxt;
  logic tx_valid_r, tx_valid_nxt;

  // count plus processing delay, referred to first header sample
  always_comb begin
    tx_stamp_nxt = tx_stamp_r;
    tx_valid_nxt = 1'b0;
    if (tx_req_i) begin
      tx_stamp_nxt = phase_count_r + tx_delay_ticks_i;
      tx_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tx_stamp_r <= MPD_COUNT_RST;
      tx_valid_r <= 1'b0;
    end else if (ce_i) begin
      tx_stamp_r <= tx_stamp_nxt;
      tx_valid_r <= tx_valid_nxt;
    end
  end

  assign tx_phase_stamp_o = tx_stamp_r;
  assign tx_stamp_valid_o = tx_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // receive computation

  mpd_state_e state_r, state_nxt;
  mpd_rx_job_s job_r, job_nxt;
  mpd_count_t rx_stamp_r, rx_stamp_nxt;
  logic [MPD_COUNT_W:0] delta_r, delta_nxt;
  mpd_result_s res_r, res_nxt;
  logic res_valid_r, res_valid_nxt;
  logic [MPD_COUNT_W+7:0] scaled;
  logic [MPD_CODE_W:0] rounded;

  // round(delta*100/4266): add half divisor then divide; yields 0..6
  always_comb begin
    scaled = 16'((32'(delta_r) * 32'h0000_0064 + 32'(MPD_SIXTY_DEG_X100 / 2)) / 32'(MPD_SIXTY_DEG_X100));
    rounded = scaled[MPD_CODE_W:0];
  end

  // detect, delta with wrap, code, store
  always_comb begin
    state_nxt = state_r;
    job_nxt = job_r;
    rx_stamp_nxt = rx_stamp_r;
    delta_nxt = delta_r;
    res_nxt = res_r;
    res_valid_nxt = 1'b0;
    case (state_r)
      MPD_IDLE: begin
        if (rx_detect_i) begin
          job_nxt = rx_job_i;
          rx_stamp_nxt = phase_count_r - rx_job_i.rx_delay_ticks;
          state_nxt = MPD_DELTA;
        end
      end
      MPD_DELTA: begin
        delta_nxt = {1'b0, rx_stamp_r} - {1'b0, job_r.tx_phase_stamp};
        if (rx_stamp_r < job_r.tx_phase_stamp) begin
          delta_nxt = {1'b0, rx_stamp_r} - {1'b0, job_r.tx_phase_stamp} + MPD_WRAP;
        end
        state_nxt = MPD_CODE;
      end
      MPD_CODE: begin
        // a rounded result of six folds back to zero
        res_nxt.phase_offset_code = (rounded >= 4'h6) ? 3'(rounded - 4'h6) : rounded[MPD_CODE_W-1:0];
        state_nxt = MPD_STORE;
      end
      MPD_STORE: begin
        res_nxt.inverted = res_r.phase_offset_code[0];
        res_valid_nxt = 1'b1;
        state_nxt = MPD_IDLE;
      end
      default: begin
        state_nxt = MPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r <= MPD_IDLE;
      job_r <= '0;
      rx_stamp_r <= MPD_COUNT_RST;
      delta_r <= '0;
      res_r <= '0;
      res_valid_r <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      job_r <= job_nxt;
      rx_stamp_r <= rx_stamp_nxt;
      delta_r <= delta_nxt;
      res_r <= res_nxt;
      res_valid_r <= res_valid_nxt;
    end
  end

  assign phase_offset_code_o = res_r.phase_offset_code;
  assign inverted_o = res_r.inverted;
  assign result_valid_o = res_valid_r;
  assign phase_count_o = phase_count_r;

  ////////////////////////////////////////////////////////////////////////////
  // neighbour table and get path

  mpd_result_s mem_rd;
  logic get_valid_r, get_valid_nxt;

  // store result into entry at the end of computation
  mpd_nbr_mem #(
    .DEPTH(NBR_DEPTH),
    .AW(MPD_NBR_W)
  ) u_nbr_mem (
    .core_clk_i(core_clk_i),
    .ce_i(ce_i),
    .wr_en_i(state_r == MPD_STORE),
    .wr_addr_i(job_r.nbr_idx),
    .wr_data_i({res_r.phase_offset_code, res_r.phase_offset_code[0]}),
    .rd_addr_i(get_idx_i),
    .rd_data_o(mem_rd)
  );

  // get answer one cycle after request
  always_comb begin
    get_valid_nxt = get_req_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      get_valid_r <= 1'b0;
    end else if (ce_i) begin
      get_valid_r <= get_valid_nxt;
    end
  end

  assign get_data_o = mem_rd;
  assign get_valid_o = get_valid_r;

endmodule : mpd_phase_detector
`default_nettype wire

/* mpd_phase_chk.sv */
// mpd_phase_chk: port-level checks of the phase detector
// assumes bind onto mpd_phase_detector, single clock domain
`timescale 1ns/100ps
`default_nettype none
module mpd_phase_chk
  import mpd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic zc_pulse_i,
  input wire logic tx_req_i,
  input wire logic tx_stamp_valid_o,
  input wire logic rx_detect_i,
  input wire mpd_code_t phase_offset_code_o,
  input wire logic inverted_o,
  input wire logic result_valid_o,
  input wire logic get_req_i,
  input wire logic get_valid_o,
  input wire mpd_count_t phase_count_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  property p_zc; zc_pulse_i && ce_i |=> phase_count_o == 8'h00; endproperty
  a_zc: assert property (p_zc) else $error("count not cleared");
  property p_step; $changed(phase_count_o) |-> phase_count_o == 8'h00 ||
    phase_count_o == 8'($past(phase_count_o) + 8'h01); endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_txv; tx_req_i && ce_i |=> tx_stamp_valid_o; endproperty
  a_txv: assert property (p_txv) else $error("no tx stamp");
  property p_txp; tx_stamp_valid_o |-> $past(tx_req_i); endproperty
  a_txp: assert property (p_txp) else $error("stray tx stamp");
  property p_lat; result_valid_o |-> $past(rx_detect_i, 4) ##1 !result_valid_o [*3]; endproperty
  a_lat: assert property (p_lat) else $error("result timing");
  property p_inv; result_valid_o |-> inverted_o == phase_offset_code_o[0]; endproperty
  a_inv: assert property (p_inv) else $error("inversion flag");
  property p_rng; result_valid_o |-> phase_offset_code_o <= 3'h5; endproperty
  a_rng: assert property (p_rng) else $error("code range");
  property p_get; get_req_i && ce_i |=> get_valid_o; endproperty
  a_get: assert property (p_get) else $error("no get answer");
endmodule : mpd_phase_chk
bind mpd_phase_detector mpd_phase_chk u_chk (.core_clk_i, .rst_n_i, .ce_i, .zc_pulse_i, .tx_req_i,
  .tx_stamp_valid_o, .rx_detect_i, .phase_offset_code_o, .inverted_o, .result_valid_o, .get_req_i,
  .get_valid_o, .phase_count_o);
`default_nettype wire

/* mpd_zc_model.sv */
// mpd_zc_model: zero-crossing source, one pulse per mains period
// assumes period shortened to keep the run brief
`timescale 1ns/100ps
`default_nettype none
module mpd_zc_model #(
  parameter int unsigned PERIOD = 20000
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  output logic zc_pulse_o
);
  logic [15:0] cyc_r;
  // period counter, pulse at rising crossing only
  always_ff @(posedge core_clk_i) begin
    cyc_r <= (!rst_n_i || cyc_r == 16'(PERIOD - 1)) ? 16'h0000 : cyc_r + 16'h0001;
    zc_pulse_o <= rst_n_i && cyc_r == 16'(PERIOD - 1);
  end
endmodule : mpd_zc_model
`default_nettype wire

/* mains_phase_detector_bench.sv */
// mains_phase_detector_bench: directed tests of the phase detector
// assumes outputs read at the edge, before that edge's updates land
`timescale 1ns/100ps
`default_nettype none
module mains_phase_detector_bench;
  import mpd_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  logic zc, m60 = 1'b0, txr = 1'b0, txv, det = 1'b0, inv, rv, gr = 1'b0, gv;
  mpd_count_t txd = 8'h00, txs, cnt;
  mpd_rx_job_s job = '0;
  mpd_code_t code;
  logic [4:0] gi = 5'h00;
  mpd_result_s gd;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  mpd_count_t dly [10] = '{8'h00, 8'h00, 8'h00, 8'h38, 8'h38, 8'h38, 8'h38, 8'h01, 8'h00, 8'h38};
  mpd_count_t stp [10] = '{8'h00, 8'heb, 8'hea, 8'h00, 8'h5f, 8'h5d, 8'h96, 8'h00, 8'h16, 8'h18};
  mpd_code_t want [10];
  mpd_zc_model u_zc (.core_clk_i, .rst_n_i, .zc_pulse_o(zc));
  mpd_phase_detector u_dut (.core_clk_i, .rst_n_i, .ce_i(ce), .zc_pulse_i(zc), .mains_60hz_i(m60),
    .tx_req_i(txr), .tx_delay_ticks_i(txd), .tx_phase_stamp_o(txs), .tx_stamp_valid_o(txv), .rx_detect_i(det),
    .rx_job_i(job), .phase_offset_code_o(code), .inverted_o(inv), .result_valid_o(rv), .get_req_i(gr),
    .get_idx_i(gi), .get_data_o(gd), .get_valid_o(gv), .phase_count_o(cnt));
  ////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : step
  // wide enough for a valid bit joined to a stamp
  task automatic chk(input logic [15:0] s, input logic [15:0] w);
    checks_done++;
    if (s !== w) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h, expected %h", $time, s, w);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // count clears on crossing, ticks after one divider span
  task automatic t_count(input logic m, input int div);
    m60 <= m;
    do step(1); while (zc !== 1'b1);
    step(div);
    chk(cnt, 8'h00);
    step(1);
    chk(cnt, 8'h01);
    $display("t_count done");
  endtask : t_count
  // neighbour stamps arrive in jobs; count is zero throughout
  task automatic t_rx();
    do step(1); while (zc !== 1'b1);
    for (int i = 0; i < 10; i++) begin
      want[i] = 3'(((((0 - int'(dly[i]) - int'(stp[i])) & 255) * 200 + MPD_SIXTY_DEG_X100)
        / (2 * MPD_SIXTY_DEG_X100)) % 6);
      job <= '{5'(i), stp[i], dly[i]};
      det <= 1'b1;
      step(1);
      det <= 1'b0;
      for (int n = 0; n < 8 && rv !== 1'b1; n++) step(1);
      chk(rv, 8'h01);
      chk(code, want[i]);
      chk(inv, 8'(want[i][0]));
    end
    // back-to-back reads of every stored entry
    for (int i = 0; i < 12; i++) begin
      if (i > 1) chk(gv, 8'h01);
      if (i > 1) chk(gd, {want[i-2], want[i-2][0]});
      gi <= 5'(i);
      gr <= i < 10;
      step(1);
    end
    $display("t_rx done");
  endtask : t_rx
  // back-to-back stamps at count zero, one at the top value 255
  task automatic t_tx();
    txr <= 1'b1;
    txd <= 8'hff;
    step(1);
    txd <= 8'h05;
    step(1);
    txr <= 1'b0;
    chk({txv, txs}, 9'h1ff);
    step(1);
    chk({txv, txs}, 9'h105);
    step(1);
    chk({txv, txs}, 9'h005);
    $display("t_tx done");
  endtask : t_tx
  // enable low freezes a pending stamp request, enable high takes it
  task automatic t_ce();
    ce <= 1'b0;
    txr <= 1'b1;
    txd <= 8'h33;
    step(2);
    chk({txv, txs}, 9'h005);
    ce <= 1'b1;
    step(1);
    txr <= 1'b0;
    step(1);
    chk({txv, txs}, 9'h133);
    $display("t_ce done");
  endtask : t_ce
  // mid-run reset clears stamp and count, counting resumes from zero
  task automatic t_rst();
    rst_n_i <= 1'b0;
    step(2);
    chk({txv, txs}, 9'h000);
    rst_n_i <= 1'b1;
    step(2);
    chk(cnt, 8'h00);
    $display("t_rst done");
  endtask : t_rst
  // clock and cycle ceiling
  initial forever #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      bad_count++;
      test_done();
    end
  end
  // reset, then the tests in turn
  initial begin
    step(3);
    rst_n_i <= 1'b1;
    t_count(1'b0, MPD_DIV_50);
    t_count(1'b1, MPD_DIV_60);
    t_rx();
    t_tx();
    t_ce();
    t_rst();
    test_done();
  end
endmodule : mains_phase_detector_bench
`default_nettype wire
